// file: logic/alsw_pkg.sv
// Purpose: shared constants for the record-path first-order filter and
//    stereo widening block
// Assumes: register indices as printed; byte address is four times index
// Notes: all registers are 16 bits wide in the low half of a 32-bit word
package alsw_pkg;
   // sample and coefficient widths
   localparam int SAMPLE_W = 24;
   localparam int COEF_W = 16;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   // register indices
   localparam logic [IDX_W-1:0] IDX_FO_CTRL = 10'h108;
   localparam logic [IDX_W-1:0] IDX_FO_COEF = 10'h109;
   localparam logic [IDX_W-1:0] IDX_WIDE_CTRL = 10'h10C;
   localparam logic [IDX_W-1:0] IDX_LEFT_GD = 10'h10D;
   localparam logic [IDX_W-1:0] IDX_XF_COEF = 10'h10E;
   localparam logic [IDX_W-1:0] IDX_RIGHT_GD = 10'h10F;
   localparam logic [IDX_W-1:0] IDX_MONO = 10'h110;
   // field positions
   localparam int FO_EN_BIT = 0;
   localparam int FO_TYPE_BIT = 1;
   localparam int WIDE_EN_BIT = 0;
   localparam int XF_EN_BIT = 1;
   localparam int XF_TYPE_BIT = 2;
   localparam int RIGHT_NEG_BIT = 4;
   localparam int LEFT_NEG_BIT = 5;
   localparam int FGAIN_LSB = 11;
   localparam int CGAIN_LSB = 6;
   localparam int DELAY_LSB = 2;
   localparam int GAIN_W = 5;
   localparam int DELAY_W = 4;
   localparam int MONO_W = 2;
   localparam int GAIN_FRAC = 15;
   localparam logic [DELAY_W-1:0] MAX_DELAY = 4'h8;
   // reset value and write masks
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] WIDE_CTRL_MASK = 16'h0037;
   localparam logic [15:0] GD_MASK = 16'hFFFC;
   localparam logic [15:0] FO_CTRL_MASK = 16'h0003;
   localparam logic [15:0] MONO_MASK = 16'h0003;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // record mono-mix modes, used only while widening is off
   typedef enum logic [MONO_W-1:0]
   {
      ALSW_MONO_OFF,
      ALSW_MONO_LEFT,
      ALSW_MONO_RIGHT,
      ALSW_MONO_AVG
   } alsw_mono_t;
endpackage : alsw_pkg

// file: logic/alsw_top.sv
// Purpose: first-order low/high-pass stage followed by stereo widening
// Assumes: one stereo sample per in_valid pulse, spaced two cycles or more
// Notes: AXI4-Lite slave, one write and one read outstanding at a time
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// - The first-order stage passes audio untouched while its enable bit is 0 and filters when it is 1.
// - The first-order stage is low-pass when its type bit is 0 and high-pass when it is 1.
// - The first-order stage response follows a software-loaded coefficient register.
// - Widening is switched on by bit 0 of its control register and then overrides any mono-mix choice.
// - With widening on, each output is forward-gained same channel plus cross-gained opposite channel.
// - A set cross polarity bit subtracts that channel's cross term instead of adding it.
// - Each cross feed is delayed 0 to 8 whole samples by a 4-bit field; larger codes are reserved.
// - Gain codes give mute at 0, -11.25 dB at 1 and 0.375 dB more per step up to 0 dB at 31.
// - Forward gain sits in bits 15:11 and cross gain in 10:6, all zero and so muted at reset.
// - An optional cross-feed filter is enabled by bit 1 and set low-pass or high-pass by bit 2.
// - The cross-feed filter response follows its own software-loaded coefficient register.
// - The filter stage and the widening stage process each stereo sample in sequence.
module alsw_top #(
   parameter int W = alsw_pkg::SAMPLE_W,
   parameter int CW = alsw_pkg::COEF_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [alsw_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [alsw_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // sample stream in
   input wire logic in_valid,
   input wire logic signed [W-1:0] in_left,
   input wire logic signed [W-1:0] in_right,
   // sample stream out
   output logic out_valid,
   output logic signed [W-1:0] out_left,
   output logic signed [W-1:0] out_right
);
   import alsw_pkg::*;

   if (W < 8 || W > 32 || CW < 4 || CW > 16)
   begin : g_check
      $error("alsw_top: unsupported sample or coefficient width");
   end

   localparam logic signed [W+1:0] SMAX = {3'b000, {(W-1){1'b1}}};
   localparam logic signed [W+1:0] SMIN = {3'b111, {(W-1){1'b0}}};

   function automatic logic signed [W-1:0] sat(input logic signed [W+1:0] v);
      if (v > SMAX)
      begin
         sat = SMAX[W-1:0];
      end
      else if (v < SMIN)
      begin
         sat = SMIN[W-1:0];
      end
      else
      begin
         sat = v[W-1:0];
      end
   endfunction : sat

   // one-pole smoother: st moves toward x by k / 2^CW
   function automatic logic signed [W-1:0] lp_next(
      input logic signed [W-1:0] x,
      input logic signed [W-1:0] st,
      input logic [CW-1:0] k);
      logic signed [W:0] d;
      logic signed [W+CW+1:0] p;
      d = {x[W-1], x} - {st[W-1], st};
      p = d * $signed({1'b0, k});
      p = p >>> CW;
      lp_next = st + p[W-1:0];
   endfunction : lp_next

   function automatic logic signed [W-1:0] filt(
      input logic en,
      input logic hp,
      input logic signed [W-1:0] x,
      input logic signed [W-1:0] lp);
      if (!en)
      begin
         filt = x;
      end
      else if (hp)
      begin
         filt = sat({{2{x[W-1]}}, x} - {{2{lp[W-1]}}, lp});
      end
      else
      begin
         filt = lp;
      end
   endfunction : filt

   // q1.15 gain, 0.375 dB per code, each rounded to nearest; unity exact
   function automatic logic [15:0] gain_q15(input logic [GAIN_W-1:0] c);
      case (c)
         5'h00: gain_q15 = 16'h0000;
         5'h01: gain_q15 = 16'h230D;
         5'h02: gain_q15 = 16'h2499;
         5'h03: gain_q15 = 16'h2636;
         5'h04: gain_q15 = 16'h27E6;
         5'h05: gain_q15 = 16'h29A9;
         5'h06: gain_q15 = 16'h2B7F;
         5'h07: gain_q15 = 16'h2D6B;
         5'h08: gain_q15 = 16'h2F6B;
         5'h09: gain_q15 = 16'h3183;
         5'h0A: gain_q15 = 16'h33B2;
         5'h0B: gain_q15 = 16'h35FA;
         5'h0C: gain_q15 = 16'h385C;
         5'h0D: gain_q15 = 16'h3AD8;
         5'h0E: gain_q15 = 16'h3D71;
         5'h0F: gain_q15 = 16'h4027;
         5'h10: gain_q15 = 16'h42FB;
         5'h11: gain_q15 = 16'h45F0;
         5'h12: gain_q15 = 16'h4906;
         5'h13: gain_q15 = 16'h4C3F;
         5'h14: gain_q15 = 16'h4F9C;
         5'h15: gain_q15 = 16'h531F;
         5'h16: gain_q15 = 16'h56CA;
         5'h17: gain_q15 = 16'h5A9E;
         5'h18: gain_q15 = 16'h5E9D;
         5'h19: gain_q15 = 16'h62CA;
         5'h1A: gain_q15 = 16'h6726;
         5'h1B: gain_q15 = 16'h6BB3;
         5'h1C: gain_q15 = 16'h7073;
         5'h1D: gain_q15 = 16'h7569;
         5'h1E: gain_q15 = 16'h7A97;
         default: gain_q15 = 16'h8000;
      endcase
   endfunction : gain_q15

   function automatic logic signed [W-1:0] mix(
      input logic signed [W-1:0] fwd,
      input logic [GAIN_W-1:0] fg,
      input logic signed [W-1:0] xs,
      input logic [GAIN_W-1:0] cg,
      input logic neg);
      logic signed [W+16:0] a;
      logic signed [W+16:0] b;
      logic signed [W+17:0] s;
      a = fwd * $signed({1'b0, gain_q15(fg)});
      b = xs * $signed({1'b0, gain_q15(cg)});
      s = neg ? a - b : a + b;
      s = s >>> GAIN_FRAC;
      mix = sat(s[W+1:0]);
   endfunction : mix

   // reserved delay codes act as the longest delay
   function automatic logic [DELAY_W-1:0] dly(input logic [15:0] gd);
      dly = (gd[DELAY_LSB+:DELAY_W] > MAX_DELAY) ? MAX_DELAY
         : gd[DELAY_LSB+:DELAY_W];
   endfunction : dly

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] be, input logic [15:0] m);
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]} & m;
   endfunction : merge

   // bus slave state
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic aw_held_reg, w_held_reg;
   logic [IDX_W-1:0] aw_idx_reg;
   logic [15:0] w_data_reg;
   logic [1:0] w_strb_reg, bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   // software registers
   logic [15:0] fo_ctrl_reg, fo_coef_reg, wide_ctrl_reg, xf_coef_reg;
   logic [15:0] left_gd_reg, right_gd_reg, mono_reg;
   // sample path state
   logic signed [W-1:0] fo_st_l_reg, fo_st_r_reg, xf_st_l_reg, xf_st_r_reg;
   logic signed [W-1:0] hist_l_reg [1:8];
   logic signed [W-1:0] hist_r_reg [1:8];
   logic out_valid_reg;
   logic signed [W-1:0] out_left_reg, out_right_reg;

   wire aw_take = awvalid && awready_reg;
   wire w_take = wvalid && wready_reg;
   wire wfire = aw_held_reg && w_held_reg && !bvalid_reg;
   wire b_done = bvalid_reg && bready;
   wire ar_take = arvalid && arready_reg;
   wire r_done = rvalid_reg && rready;
   wire [IDX_W-1:0] ar_idx = araddr[ADDR_W-1:2];
   wire [IDX_W-1:0] aw_idx = awaddr[ADDR_W-1:2];
   wire w_hit = aw_idx_reg inside {IDX_FO_CTRL, IDX_FO_COEF, IDX_WIDE_CTRL,
      IDX_LEFT_GD, IDX_XF_COEF, IDX_RIGHT_GD, IDX_MONO};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_idx_reg <= '0;
         w_data_reg <= REG_RESET;
         w_strb_reg <= 2'h0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_idx_reg <= aw_idx;
         end
         if (w_take)
         begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            w_data_reg <= wdata[15:0];
            w_strb_reg <= wstrb[1:0];
         end
         if (wfire)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (b_done)
         begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   wire we_fo_ctrl = wfire && aw_idx_reg == IDX_FO_CTRL;
   wire we_fo_coef = wfire && aw_idx_reg == IDX_FO_COEF;
   wire we_wide = wfire && aw_idx_reg == IDX_WIDE_CTRL;
   wire we_left = wfire && aw_idx_reg == IDX_LEFT_GD;
   wire we_xf_coef = wfire && aw_idx_reg == IDX_XF_COEF;
   wire we_right = wfire && aw_idx_reg == IDX_RIGHT_GD;
   wire we_mono = wfire && aw_idx_reg == IDX_MONO;
   wire [15:0] coef_mask = 16'(({CW{1'b1}}));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fo_ctrl_reg <= REG_RESET;
         fo_coef_reg <= REG_RESET;
         wide_ctrl_reg <= REG_RESET;
         xf_coef_reg <= REG_RESET;
         left_gd_reg <= REG_RESET;
         right_gd_reg <= REG_RESET;
         mono_reg <= REG_RESET;
      end
      else
      begin
         if (we_fo_ctrl)
            fo_ctrl_reg <= merge(fo_ctrl_reg, w_data_reg, w_strb_reg,
               FO_CTRL_MASK);
         if (we_fo_coef)
            fo_coef_reg <= merge(fo_coef_reg, w_data_reg, w_strb_reg,
               coef_mask);
         if (we_wide)
            wide_ctrl_reg <= merge(wide_ctrl_reg, w_data_reg, w_strb_reg,
               WIDE_CTRL_MASK);
         if (we_left)
            left_gd_reg <= merge(left_gd_reg, w_data_reg, w_strb_reg,
               GD_MASK);
         if (we_xf_coef)
            xf_coef_reg <= merge(xf_coef_reg, w_data_reg, w_strb_reg,
               coef_mask);
         if (we_right)
            right_gd_reg <= merge(right_gd_reg, w_data_reg, w_strb_reg,
               GD_MASK);
         if (we_mono)
            mono_reg <= merge(mono_reg, w_data_reg, w_strb_reg, MONO_MASK);
      end
   end

   logic [15:0] rd_val;
   logic rd_hit;
   always_comb
   begin
      rd_hit = 1'b1;
      if (ar_idx == IDX_FO_CTRL)
         rd_val = fo_ctrl_reg;
      else if (ar_idx == IDX_FO_COEF)
         rd_val = fo_coef_reg;
      else if (ar_idx == IDX_WIDE_CTRL)
         rd_val = wide_ctrl_reg;
      else if (ar_idx == IDX_LEFT_GD)
         rd_val = left_gd_reg;
      else if (ar_idx == IDX_XF_COEF)
         rd_val = xf_coef_reg;
      else if (ar_idx == IDX_RIGHT_GD)
         rd_val = right_gd_reg;
      else if (ar_idx == IDX_MONO)
         rd_val = mono_reg;
      else
      begin
         rd_val = REG_RESET;
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {16'h0000, rd_val};
         rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_done)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   // whole sample is computed from one snapshot of settings in one cycle,
   // so a register write can never split a sample
   wire fo_en = fo_ctrl_reg[FO_EN_BIT];
   wire fo_hp = fo_ctrl_reg[FO_TYPE_BIT];
   wire wide_en = wide_ctrl_reg[WIDE_EN_BIT];
   wire xf_en = wide_ctrl_reg[XF_EN_BIT];
   wire xf_hp = wide_ctrl_reg[XF_TYPE_BIT];
   wire [CW-1:0] fo_k = fo_coef_reg[CW-1:0];
   wire [CW-1:0] xf_k = xf_coef_reg[CW-1:0];
   wire signed [W-1:0] fo_lp_l = lp_next(in_left, fo_st_l_reg, fo_k);
   wire signed [W-1:0] fo_lp_r = lp_next(in_right, fo_st_r_reg, fo_k);
   wire signed [W-1:0] f1_l = filt(fo_en, fo_hp, in_left, fo_lp_l);
   wire signed [W-1:0] f1_r = filt(fo_en, fo_hp, in_right, fo_lp_r);
   // cross source into left is the right channel and vice versa
   wire signed [W-1:0] xf_lp_l = lp_next(f1_r, xf_st_l_reg, xf_k);
   wire signed [W-1:0] xf_lp_r = lp_next(f1_l, xf_st_r_reg, xf_k);
   wire signed [W-1:0] xs_l = filt(xf_en, xf_hp, f1_r, xf_lp_l);
   wire signed [W-1:0] xs_r = filt(xf_en, xf_hp, f1_l, xf_lp_r);
   wire [DELAY_W-1:0] d_l = dly(left_gd_reg);
   wire [DELAY_W-1:0] d_r = dly(right_gd_reg);
   wire signed [W-1:0] xd_l = (d_l == 4'h0) ? xs_l : hist_l_reg[d_l];
   wire signed [W-1:0] xd_r = (d_r == 4'h0) ? xs_r : hist_r_reg[d_r];
   wire signed [W-1:0] wl = mix(f1_l, left_gd_reg[FGAIN_LSB+:GAIN_W], xd_l,
      left_gd_reg[CGAIN_LSB+:GAIN_W], wide_ctrl_reg[LEFT_NEG_BIT]);
   wire signed [W-1:0] wr = mix(f1_r, right_gd_reg[FGAIN_LSB+:GAIN_W], xd_r,
      right_gd_reg[CGAIN_LSB+:GAIN_W], wide_ctrl_reg[RIGHT_NEG_BIT]);
   wire alsw_mono_t mono_sel = alsw_mono_t'(mono_reg[MONO_W-1:0]);
   wire signed [W+1:0] mono_sum = {{2{f1_l[W-1]}}, f1_l}
      + {{2{f1_r[W-1]}}, f1_r};
   wire signed [W+1:0] mono_half = mono_sum >>> 1;
   wire signed [W-1:0] mono_avg = mono_half[W-1:0];
   wire signed [W-1:0] ml = (mono_sel == ALSW_MONO_RIGHT) ? f1_r
      : (mono_sel == ALSW_MONO_AVG) ? mono_avg : f1_l;
   wire signed [W-1:0] mr = (mono_sel == ALSW_MONO_LEFT) ? f1_l
      : (mono_sel == ALSW_MONO_AVG) ? mono_avg : f1_r;
   wire signed [W-1:0] nl = wide_en ? wl : ml;
   wire signed [W-1:0] nr = wide_en ? wr : mr;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fo_st_l_reg <= '0;
         fo_st_r_reg <= '0;
         xf_st_l_reg <= '0;
         xf_st_r_reg <= '0;
      end
      else if (in_valid)
      begin
         fo_st_l_reg <= fo_en ? fo_lp_l : fo_st_l_reg;
         fo_st_r_reg <= fo_en ? fo_lp_r : fo_st_r_reg;
         xf_st_l_reg <= xf_en ? xf_lp_l : xf_st_l_reg;
         xf_st_r_reg <= xf_en ? xf_lp_r : xf_st_r_reg;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 1; i <= 8; i++)
         begin
            hist_l_reg[i] <= '0;
            hist_r_reg[i] <= '0;
         end
      end
      else if (in_valid)
      begin
         hist_l_reg[1] <= xs_l;
         hist_r_reg[1] <= xs_r;
         for (int i = 2; i <= 8; i++)
         begin
            hist_l_reg[i] <= hist_l_reg[i-1];
            hist_r_reg[i] <= hist_r_reg[i-1];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_valid_reg <= 1'b0;
         out_left_reg <= '0;
         out_right_reg <= '0;
      end
      else
      begin
         out_valid_reg <= in_valid;
         if (in_valid)
         begin
            out_left_reg <= nl;
            out_right_reg <= nr;
         end
      end
   end

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign out_valid = out_valid_reg;
   assign out_left = out_left_reg;
   assign out_right = out_right_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_plain_in;
      in_valid && !fo_en && !wide_en && mono_sel == ALSW_MONO_OFF;
   endsequence
   sequence s_unity_cross;
      in_valid && wide_en && !xf_en && !fo_en && d_l == 4'h0
         && left_gd_reg[FGAIN_LSB+:GAIN_W] == 5'h00
         && left_gd_reg[CGAIN_LSB+:GAIN_W] == 5'h1F;
   endsequence

   AST_BYPASS: assert property (s_plain_in |=> out_valid
      && out_left == $past(in_left) && out_right == $past(in_right))
      else $error("bypass changed the samples");
   AST_MUTE_OVERRIDE: assert property (in_valid && wide_en
      && left_gd_reg[15:6] == 10'h000 |=> out_left == 0)
      else $error("muted widening left nonzero or mono mix leaked");
   AST_CROSS_ADD: assert property ((s_unity_cross
      and !wide_ctrl_reg[LEFT_NEG_BIT]) |=> out_left == $past(in_right))
      else $error("unity cross feed not copied");
   AST_CROSS_NEG: assert property ((s_unity_cross
      and (wide_ctrl_reg[LEFT_NEG_BIT] && in_right != SMIN[W-1:0]))
      |=> out_left == -$past(in_right))
      else $error("negative cross feed not subtracted");
   AST_DELAY_ONE: assert property (in_valid && wide_en && !xf_en
      && !fo_en && d_l == 4'h1 && left_gd_reg[15:6] == 10'h01F
      && !wide_ctrl_reg[LEFT_NEG_BIT] |=> out_left == $past(hist_l_reg[1]))
      else $error("one-sample cross delay not applied");
   AST_DELAY_HIST: assert property (in_valid |=> hist_l_reg[1] == $past(xs_l)
      && hist_l_reg[2] == $past(hist_l_reg[1]))
      else $error("cross delay line did not shift");
   AST_GAIN_RESET: assert property (disable iff (1'b0) !aresetn
      |=> left_gd_reg == 16'h0000 && right_gd_reg == 16'h0000)
      else $error("gain fields not cleared by reset");
   AST_HOLD: assert property (!in_valid |=> $stable(out_left)
      && $stable(out_right) && !out_valid)
      else $error("output moved without a sample");
   AST_SATURATE: assert property (in_valid && wide_en && !xf_en
      && !fo_en && d_l == 4'h0 && left_gd_reg[15:6] == 10'h3FF
      && !wide_ctrl_reg[LEFT_NEG_BIT]
      && in_left == SMAX[W-1:0] && in_right == SMAX[W-1:0]
      |=> out_left == SMAX[W-1:0])
      else $error("mix wrapped instead of saturating");
   AST_LP_COEF_ZERO: assert property (in_valid && fo_en && !fo_hp
      && fo_k == '0 |=> fo_st_l_reg == $past(fo_st_l_reg))
      else $error("low-pass state moved with zero coefficient");
endmodule : alsw_top

// file: tb/alsw_src.sv
// Purpose: upstream sample source feeding the record path
// Assumes: one go pulse per stereo sample
// Notes: released data lines invert every idle cycle, alternating between the inverse of the last sample and the sample
`timescale 1ns/1ps
module alsw_src (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // request from bench
   input wire logic go,
   input wire logic signed [23:0] l,
   input wire logic signed [23:0] r,
   // stream to block
   output logic in_valid,
   output logic signed [23:0] in_left,
   output logic signed [23:0] in_right
);
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_valid <= 1'b0;
         in_left <= 24'h00_0000;
         in_right <= 24'h00_0000;
      end
      else if (go)
      begin
         // left and right always leave together, one pulse each
         in_valid <= 1'b1;
         in_left <= l;
         in_right <= r;
      end
      else
      begin
         // stale data must never look valid
         in_valid <= 1'b0;
         in_left <= ~in_left;
         in_right <= ~in_right;
      end
   end
endmodule : alsw_src

// file: tb/alsw_top_tb.sv
// Purpose: self-checking bench for the filter and widening block
// Assumes: 125 MHz clock, register byte address is four times index
// Notes: no random stimulus; watchdog ends a hang
`timescale 1ns/1ps
module alsw_top_tb;
   import alsw_pkg::*;
   logic aclk = 0, aresetn = 0, go = 0, awvalid = 0, wvalid = 0;
   logic bready = 0, arvalid = 0, rready = 0, in_valid, out_valid;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, rs;
   logic signed [23:0] l = 0, r = 0, in_left, in_right, out_left, out_right;
   int miscompares = 0, tests_run = 0;
   always #4 aclk = ~aclk;
   alsw_src alsw_src_i (.aclk(aclk), .aresetn(aresetn), .go(go), .l(l),
      .r(r), .in_valid(in_valid), .in_left(in_left), .in_right(in_right));
   alsw_top alsw_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
      .out_valid(out_valid), .out_left(out_left), .out_right(out_right));
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : check
   task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] b);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      forever
      begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      b = bresp;
      bready <= 0;
   endtask : wr
   task rdreg(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      forever
      begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      rd = rdata;
      rs = rresp;
      rready <= 0;
   endtask : rdreg
   task smp(input logic [23:0] a, input logic [23:0] b, input logic [23:0] ea,
      input logic [23:0] eb);
      @(posedge aclk);
      go <= 1;
      l <= a;
      r <= b;
      @(posedge aclk);
      go <= 0;
      @(posedge aclk);
      @(negedge aclk);
      check("out_valid", {31'h0, out_valid}, 32'h0000_0001);
      check("out_left", {8'h00, out_left}, {8'h00, ea});
      check("out_right", {8'h00, out_right}, {8'h00, eb});
   endtask : smp
   task t_regs;
      logic [1:0] b;
      rdreg(12'h420);
      check("fo_ctrl", rd, 32'h0000_0000);
      rdreg(12'h434);
      check("left_gd", rd, 32'h0000_0000);
      rdreg(12'h43c);
      check("right_gd", rd, 32'h0000_0000);
      rdreg(12'h7fc);
      check("unmapped_rresp", {30'h0, rs}, 32'h0000_0002);
      wr(12'h7f0, 32'h0000_ffff, b);
      check("unmapped_bresp", {30'h0, b}, 32'h0000_0002);
      wr(12'h430, 32'h0000_ffff, b);
      check("mapped_bresp", {30'h0, b}, 32'h0000_0000);
      rdreg(12'h430);
      check("widen_ctrl", rd, 32'h0000_0037);
      wr(12'h430, 32'h0000_0000, b);
   endtask : t_regs
   task t_first_order;
      logic [1:0] b;
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_03e8, 24'h00_00c8);
      wr(12'h420, 32'h0000_0001, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_0000, 24'h00_0000);
      wr(12'h420, 32'h0000_0003, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_03e8, 24'h00_00c8);
      wr(12'h424, 32'h0000_8000, b);
      wr(12'h420, 32'h0000_0001, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_01f4, 24'h00_0064);
      wr(12'h420, 32'h0000_0000, b);
   endtask : t_first_order
   task t_widen;
      logic [1:0] b;
      // mono mix set to left-to-both must be overruled
      wr(12'h440, 32'h0000_0001, b);
      wr(12'h430, 32'h0000_0001, b);
      wr(12'h434, 32'h0000_ffc0, b);
      wr(12'h43c, 32'h0000_ffc0, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_04b0, 24'h00_04b0);
      smp(24'h7f_ffff, 24'h7f_ffff, 24'h7f_ffff, 24'h7f_ffff);
      wr(12'h430, 32'h0000_0021, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_0320, 24'h00_04b0);
      wr(12'h430, 32'h0000_0001, b);
      wr(12'h434, 32'h0000_ffc4, b);
      rdreg(12'h434);
      check("left_gd_rb", rd, 32'h0000_ffc4);
      smp(24'h00_03e8, 24'h00_012c, 24'h00_04b0, 24'h00_0514);
      smp(24'h00_03e8, 24'h00_0000, 24'h00_0514, 24'h00_03e8);
      wr(12'h434, 32'h0000_0800, b);
      smp(24'h00_8000, 24'h00_0000, 24'h00_230d, 24'h00_8000);
      wr(12'h434, 32'h0000_0000, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_0000, 24'h00_04b0);
      // left cross only at unity: plain, negated, then one sample late
      wr(12'h434, 32'h0000_07c0, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_00c8, 24'h00_04b0);
      wr(12'h430, 32'h0000_0021, b);
      smp(24'h00_03e8, 24'h00_0064, 24'hff_ff9c, 24'h00_044c);
      wr(12'h430, 32'h0000_0001, b);
      wr(12'h434, 32'h0000_07c4, b);
      smp(24'h00_03e8, 24'h00_00c8, 24'h00_0064, 24'h00_04b0);
   endtask : t_widen
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_first_order;
      t_widen;
      complete_run;
   end
   initial
   begin
      // whole run needs well under a thousand cycles
      repeat (20000) @(posedge aclk);
      miscompares++;
      complete_run;
   end
endmodule : alsw_top_tb
